/* rtl/front_panel_standby_controller.sv */
// Standby sequencer of the front panel: switch, host request, relay and display mode.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defs.svh"
module front_panel_standby_controller
  import fpsc_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYC = `FPSC_TIMEOUT_CYC
)
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       standby_switch_input,
  input  wire logic       sclClk,
  input  wire logic       sdaIn,
  input  wire logic       i2cStart,
  output logic            sdaOutEn,
  output logic            standby_request_irq,
  output fpsc_panel_type  panel
);
  // ****************************************
  // Command reception on the link clock.
  // ****************************************
  logic [7:0] linkByte;
  logic       linkToggle;
  fpsc_i2c_target uTarget
  (
    .sclClk    (sclClk),
    .sys_rst   (sys_rst),
    .sdaIn     (sdaIn),
    .startSeen (i2cStart),
    .sdaOutEn  (sdaOutEn),
    .cmdByte   (linkByte),
    .cmdToggle (linkToggle)
  );
  // ****************************************
  // Crossings into the system clock.
  // ****************************************
  logic [2:0] togSync_q;
  logic [1:0] swSync_q;
  logic       swPrev_q;
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      togSync_q <= 3'h0;
      swSync_q  <= 2'h0;
      swPrev_q  <= 1'b0;
    end
    else
    begin
      togSync_q <= {togSync_q[1:0], linkToggle};
      swSync_q  <= {swSync_q[0], standby_switch_input};
      swPrev_q  <= swSync_q[1];
    end
  end
  logic cmdValid;
  logic swPress;
  // Byte is stable in the link domain long before its toggle is seen here.
  assign cmdValid = togSync_q[2] ^ togSync_q[1];
  assign swPress  = swSync_q[1] & ~swPrev_q;
  // ****************************************
  // Standby state machine.
  // ****************************************
  fpsc_state_type state_q, state_d;
  fpsc_disp_type  disp_q, disp_d;
  logic [31:0]    timer_q, timer_d;
  logic           timeout;
  assign timeout = (timer_q == TIMEOUT_CYC - 1);
  always_comb
  begin
    state_d = state_q;
    disp_d  = disp_q;
    timer_d = 32'h0;
    unique case (state_q)
      FPSC_NORMAL:
      begin
        if (swPress)
        begin
          state_d = FPSC_PENDING;
          disp_d  = FPSC_SHOW_STB;
        end
      end
      FPSC_PENDING:
      begin
        timer_d = timer_q + 32'h1;
        if (cmdValid && linkByte == `FPSC_CMD_STANDBY)
        begin
          state_d = FPSC_STANDBY;
          timer_d = 32'h0;
        end
        else if (cmdValid)
        begin
          state_d = FPSC_NORMAL;
          disp_d  = FPSC_SHOW_CHVOL;
          timer_d = 32'h0;
        end
        else if (timeout)
        begin
          state_d = FPSC_STANDBY;
          disp_d  = FPSC_SHOW_STB1;
          timer_d = 32'h0;
        end
      end
      FPSC_STANDBY:
      begin
        if (swPress)
        begin
          state_d = FPSC_NORMAL;
          disp_d  = FPSC_SHOW_CHVOL;
        end
      end
    endcase
  end
  always_ff @(posedge clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      state_q <= FPSC_NORMAL;
      disp_q  <= FPSC_SHOW_CHVOL;
      timer_q <= 32'h0;
    end
    else
    begin
      state_q <= state_d;
      disp_q  <= disp_d;
      timer_q <= timer_d;
    end
  end
  // ****************************************
  // Outputs.
  // ****************************************
  always_comb
  begin
    standby_request_irq = (state_q == FPSC_PENDING);
    panel.disp          = disp_q;
    panel.ledRed        = (state_q != FPSC_NORMAL);
    panel.ledGreen      = (state_q == FPSC_NORMAL);
    panel.relayOn       = (state_q != FPSC_STANDBY);
    panel.keysEnable    = (state_q == FPSC_NORMAL);
  end
  // ****************************************
  // Assertions.
  // ****************************************
  a_press_pending: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_NORMAL && swPress) |=> (state_q == FPSC_PENDING && disp_q == FPSC_SHOW_STB))
    else $error("Switch press did not start pending.");
  a_cmd_standby: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_PENDING && cmdValid && linkByte == `FPSC_CMD_STANDBY) |=> !panel.relayOn)
    else $error("Standby byte did not cut power.");
  a_cmd_cancel: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_PENDING && cmdValid && linkByte != `FPSC_CMD_STANDBY) |=> state_q == FPSC_NORMAL)
    else $error("Other byte did not cancel standby.");
  a_timeout_cut: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_PENDING && !cmdValid && timeout) |=> (!panel.relayOn && disp_q == FPSC_SHOW_STB1))
    else $error("Timeout did not cut power.");
  a_keys_off: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_STANDBY) |-> !panel.keysEnable)
    else $error("Keys enabled in standby.");
  a_wake_up: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_STANDBY && swPress) |=> (panel.relayOn && panel.ledGreen && disp_q == FPSC_SHOW_CHVOL))
    else $error("Wake did not restore power.");
  a_timer_clear: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q != FPSC_PENDING) |-> timer_q == 32'h0)
    else $error("Timer not cleared outside pending.");
  a_irq_hold: assert property (@(posedge clk) disable iff (sys_rst)
    $rose(standby_request_irq) |-> standby_request_irq until (cmdValid || timeout))
    else $error("Request line dropped early.");
  a_cancel_normal: assert property (@(posedge clk) disable iff (sys_rst)
    (state_q == FPSC_PENDING && cmdValid && linkByte != `FPSC_CMD_STANDBY) |=> (panel.ledGreen && !standby_request_irq))
    else $error("Cancel did not restore normal panel.");
  c_pending: cover property (@(posedge clk) disable iff (sys_rst) state_q == FPSC_PENDING);
  c_cmd_off: cover property (@(posedge clk) disable iff (sys_rst)
    state_q == FPSC_PENDING && cmdValid && linkByte == `FPSC_CMD_STANDBY);
  c_cancel: cover property (@(posedge clk) disable iff (sys_rst) state_q == FPSC_PENDING && cmdValid);
  c_wake: cover property (@(posedge clk) disable iff (sys_rst) state_q == FPSC_STANDBY && swPress);
endmodule : front_panel_standby_controller
`default_nettype wire

/* rtl/fpsc_defs.svh */
// Constants for the front panel standby controller.
// Notes on behaviour
// - Switch press in normal mode: pending, show Stb, red LED, raise request line.
// - Device answers as I2C target at address byte A0; host writes there.
// - Any other byte while pending cancels standby and returns to normal.
// - Standby byte while pending opens relay, cutting host power, enters standby.
// - No byte within ten seconds: cut power, enter standby, show stb1.
// - In standby, touch keys and encoder are ignored; only switch acts.
// - Switch press in standby restores power, shows channel and volume, green LED.
`ifndef FPSC_DEFS_SVH
`define FPSC_DEFS_SVH
`define FPSC_I2C_ADDR      8'hA0
`define FPSC_CMD_STANDBY   8'hAD
`define FPSC_CMD_NOACTION  8'hFD
`define FPSC_CLK_HZ        100000000
`define FPSC_TIMEOUT_S     10
`define FPSC_TIMEOUT_CYC   (`FPSC_TIMEOUT_S * `FPSC_CLK_HZ)
`endif

/* rtl/fpsc_pkg.sv */
// Types for the front panel standby controller.
package fpsc_pkg;
  typedef enum logic [1:0] {FPSC_NORMAL, FPSC_PENDING, FPSC_STANDBY} fpsc_state_type;
  typedef enum logic [1:0] {FPSC_SHOW_CHVOL, FPSC_SHOW_STB, FPSC_SHOW_STB1} fpsc_disp_type;
  typedef struct packed {
    fpsc_disp_type disp;
    logic          ledRed;
    logic          ledGreen;
    logic          relayOn;
    logic          keysEnable;
  } fpsc_panel_type;
endpackage : fpsc_pkg

/* rtl/fpsc_i2c_target.sv */
// I2C write target running on the SCL domain; delivers one command byte per transfer.
`timescale 1ns/1ps
`default_nettype none
`include "fpsc_defs.svh"
module fpsc_i2c_target
  import fpsc_pkg::*;
(
  input  wire logic       sclClk,
  input  wire logic       sys_rst,
  input  wire logic       sdaIn,
  input  wire logic       startSeen,
  output logic            sdaOutEn,
  output logic [7:0]      cmdByte,
  output logic            cmdToggle
);
  logic [3:0] bitCnt_q, bitCnt_d;
  logic [7:0] shift_q, shift_d;
  logic [1:0] phase_q, phase_d;
  logic [7:0] cmdByte_d;
  logic       cmdToggle_d;
  logic       ack_q, ack_d;
  // Phase 0 address, 1 data, 2 ignore until next start.
  always_comb
  begin
    bitCnt_d    = bitCnt_q;
    shift_d     = shift_q;
    phase_d     = phase_q;
    cmdByte_d   = cmdByte;
    cmdToggle_d = cmdToggle;
    ack_d       = 1'b0;
    if (startSeen)
    begin
      phase_d  = 2'h0;
      bitCnt_d = 4'h0;
    end
    else if (bitCnt_q == 4'h8)
      bitCnt_d = 4'h0;
    else if (phase_q != 2'h2)
    begin
      shift_d  = {shift_q[6:0], sdaIn};
      bitCnt_d = bitCnt_q + 4'h1;
      if (bitCnt_q == 4'h7)
      begin
        if (phase_q == 2'h0)
        begin
          ack_d   = ({shift_q[6:0], sdaIn} == `FPSC_I2C_ADDR);
          phase_d = ack_d ? 2'h1 : 2'h2;
        end
        else
        begin
          ack_d       = 1'b1;
          cmdByte_d   = {shift_q[6:0], sdaIn};
          cmdToggle_d = ~cmdToggle;
          phase_d     = 2'h2;
        end
      end
    end
  end
  always_ff @(posedge sclClk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      bitCnt_q  <= 4'h0;
      shift_q   <= 8'h00;
      phase_q   <= 2'h2;
      cmdByte   <= 8'h00;
      cmdToggle <= 1'b0;
      ack_q     <= 1'b0;
    end
    else
    begin
      bitCnt_q  <= bitCnt_d;
      shift_q   <= shift_d;
      phase_q   <= phase_d;
      cmdByte   <= cmdByte_d;
      cmdToggle <= cmdToggle_d;
      ack_q     <= ack_d;
    end
  end
  // Enable low pulls SDA low for the acknowledge bit.
  assign sdaOutEn = ~ack_q;
  a_addr_ack: assert property (@(posedge sclClk) disable iff (sys_rst)
    (!startSeen && phase_q == 2'h0 && bitCnt_q == 4'h7 && {shift_q[6:0], sdaIn} != `FPSC_I2C_ADDR) |=> sdaOutEn)
    else $error("Foreign address was acknowledged.");
endmodule : fpsc_i2c_target
`default_nettype wire

/* test/fpsc_host_model.sv */
// Host controller model: I2C master sending one command byte.
`timescale 1ns/1ps
`default_nettype none
module fpsc_host_model
(
  input  wire logic sdaOutEn,
  output logic      sclClk,
  output logic      sdaIn,
  output logic      i2cStart
);
  logic sdaDrv;
  assign sdaIn = sdaDrv & sdaOutEn;
  initial
  begin
    sdaDrv = 1'b1;
    i2cStart = 1'b0;
    sclClk = 1'b0;
    #5 sclClk = 1'b1;
    #10 sclClk = 1'b0;
  end
  task sendByte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--)
    begin
      sdaDrv = b[i];
      #62.5 sclClk = 1'b1;
      #62.5 sclClk = 1'b0;
    end
    sdaDrv = 1'b1;
    #62.5 ack = (sdaIn === 1'b0);
    sclClk = 1'b1;
    #62.5 sclClk = 1'b0;
  endtask : sendByte
  task send(input logic [7:0] addr, input logic [7:0] cmd, output logic ackA, output logic ackD);
    i2cStart = 1'b1;
    #62.5 sclClk = 1'b1;
    #62.5 sclClk = 1'b0;
    i2cStart = 1'b0;
    sendByte(addr, ackA);
    sendByte(cmd, ackD);
  endtask : send
endmodule : fpsc_host_model
`default_nettype wire

/* test/test_front_panel_standby_controller.sv */
// Testbench of the front panel standby controller.
`timescale 1ns/1ps
`default_nettype none
module test_front_panel_standby_controller
  import fpsc_pkg::*;
;
  logic           clk, sys_rst, stbySw, ackA, ackD;
  wire            sclClk, sdaIn, i2cStart, sdaOutEn, irq;
  fpsc_panel_type panel;
  int             err_count, checked, n;
  front_panel_standby_controller #(.TIMEOUT_CYC(1000)) front_panel_standby_controller_i (.clk(clk),
    .sys_rst(sys_rst), .standby_switch_input(stbySw), .sclClk(sclClk), .sdaIn(sdaIn), .i2cStart(i2cStart),
    .sdaOutEn(sdaOutEn), .standby_request_irq(irq), .panel(panel));
  fpsc_host_model fpsc_host_model_i (.sdaOutEn(sdaOutEn), .sclClk(sclClk), .sdaIn(sdaIn), .i2cStart(i2cStart));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task summarize;
    $display("Comparisons %0d, mismatches %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : summarize
  task waitClk(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : waitClk
  // Compares irq, display, red, green, relay and key enable against a masked pattern.
  task st(input logic [7:0] exp, input logic [7:0] m);
    check({1'b0, irq, panel} & m, exp);
  endtask : st
  task press;
    stbySw = 1'b1;
    waitClk(5);
    stbySw = 1'b0;
    waitClk(5);
  endtask : press
  task cmd(input logic [7:0] a, input logic [7:0] c);
    fpsc_host_model_i.send(a, c, ackA, ackD);
    waitClk(10);
  endtask : cmd
  task tCancel;
    press;
    st(8'h5A, 8'h7E);
    cmd(8'hA0, 8'hFD);
    check({6'h00, ackA, ackD}, 8'h03);
    st(8'h07, 8'h7F);
    $display("Cancel test done");
  endtask : tCancel
  task tStandby;
    cmd(8'hA0, 8'hAD);
    st(8'h07, 8'h7F);
    press;
    cmd(8'hA2, 8'hAD);
    check({7'h00, ackA}, 8'h00);
    st(8'h5A, 8'h7E);
    cmd(8'hA0, 8'hAD);
    st(8'h18, 8'h7F);
    cmd(8'hA0, 8'hFD);
    st(8'h18, 8'h7F);
    press;
    st(8'h07, 8'h7F);
    $display("Standby test done");
  endtask : tStandby
  task tTimeout;
    press;
    waitClk(900);
    st(8'h5A, 8'h7E);
    n = 0;
    while (panel.relayOn !== 1'b0 && n < 200)
    begin
      waitClk(1);
      n++;
    end
    if (n == 200)
      err_count++;
    st(8'h28, 8'h7F);
    press;
    st(8'h07, 8'h7F);
    $display("Timeout test done");
  endtask : tTimeout
  initial
  begin
    sys_rst = 1'b1;
    stbySw = 1'b0;
    err_count = 0;
    checked = 0;
    repeat (3) @(posedge clk);
    #1 sys_rst = 1'b0;
    waitClk(3);
    st(8'h07, 8'h7F);
    tCancel;
    tStandby;
    tTimeout;
    summarize;
  end
endmodule : test_front_panel_standby_controller
`default_nettype wire
